//--- rtl/power_mode_pkg.sv
// ============================================================
// Power mode manager shared definitions
package power_mode_pkg;

	// ============================================================
	// Register bus geometry and map
	localparam int ADDR_W = 4;
	localparam int DATA_W = 8;
	localparam logic [3:0] AUX_PRESCALER_ADDR = 4'h0;
	localparam logic [3:0] POWER_CTRL_ADDR = 4'h1;
	localparam logic [3:0] MODULE_EN_ADDR = 4'h2;
	localparam logic [3:0] STATUS_ADDR = 4'h3;

	// ============================================================
	// Reset values
	localparam logic [7:0] AUX_PRESCALER_RST = 8'hff;
	localparam logic [7:0] POWER_CTRL_RST = 8'h00;
	localparam logic [7:0] MODULE_EN_RST = 8'h03;
	localparam logic [7:0] SLOW_DIV_RST = 8'hb6;

	// ============================================================
	// Field positions
	localparam int AUX1_DIV_LSB = 0;
	localparam int AUX_DIV_W = 4;

	// Software mode codes
	localparam logic [1:0] MODE_ACTIVE = 2'h0;
	localparam logic [1:0] MODE_PSAVE = 2'h1;
	localparam logic [1:0] MODE_IDLE = 2'h2;
	localparam logic [1:0] MODE_HALT = 2'h3;

	// System clock source codes
	localparam logic [1:0] SYS_NONE = 2'h0;
	localparam logic [1:0] SYS_MAIN = 2'h1;
	localparam logic [1:0] SYS_PLL = 2'h2;
	localparam logic [1:0] SYS_SLOW = 2'h3;

	// ============================================================
	// Types
	typedef enum logic [3:0] {
		ST_ACTIVE = 4'h1,
		ST_PSAVE = 4'h2,
		ST_IDLE = 4'h4,
		ST_HALT = 4'h8
	} mode_type;

	typedef struct packed {
		logic reserved;
		logic slow_from_main;
		logic hcc_pll;
		logic hcc_main;
		logic pll_disable_bit;
		logic main_osc_disable_bit;
		logic [1:0] mode;
	} power_ctrl_type;

	typedef struct packed {
		logic [1:0] spare_en;
		logic sys_from_pll;
		logic radio_use_slow;
		logic rng_en;
		logic converter_en;
		logic aux2_en;
		logic aux1_en;
	} module_en_type;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} reg_req_type;

endpackage : power_mode_pkg

//--- rtl/power_mode_manager.sv
`timescale 1ns/1ns
`default_nettype none
module power_mode_manager
	import power_mode_pkg::*;
#(
	parameter logic [7:0] SLOW_DIV = SLOW_DIV_RST
) (
	input wire logic core_clk, // 125 MHz clock
	input wire logic srst, // Synchronous reset, high
	input wire reg_req_type bus, // Register request
	output logic [DATA_W-1:0] rdata, // Read data, next cycle
	input wire logic lf_clk_pin, // Low-frequency oscillator
	input wire logic wake_pin, // Wake-up unit event
	input wire logic sleep_req, // Processor sleep instruction
	input wire logic irq, // Interrupt to processor
	input wire logic llc_sleep, // Radio controller asleep
	output logic hf_osc_on, // High-frequency oscillator on
	output logic pll_on, // PLL on
	output logic lf_osc_on, // Low-frequency oscillator on
	output logic main_clk_on, // Main clock running
	output logic [1:0] sys_clk_sel, // System clock source
	output logic slow_tick, // Slow clock edge
	output logic watchdog_clk_on, // Timer/watchdog clock on
	output logic aux1_tick, // Auxiliary clock 1 pulse
	output logic aux2_tick, // Auxiliary clock 2 pulse
	output logic conv_clk_on, // Converter clock gate
	output logic conv_en, // Converter enable
	output logic rng_osc_on, // Random number oscillators
	output logic radio_clk_slow, // Radio uses slow clock
	output logic radio_aux_ok, // Radio aux clock usable
	output logic [1:0] spare_on, // Other switchable modules
	output logic cpu_stalled // Processor waiting
);

	// ============================================================
	// Elaboration checks
	if (2 * AUX_DIV_W != DATA_W) begin : g_bad_width
		$error("auxiliary fields must fill the register");
	end

	// ============================================================
	// Decoding helpers
	function automatic mode_type code_to_mode(input logic [1:0] code);
		case (code)
			MODE_PSAVE: code_to_mode = ST_PSAVE;
			MODE_IDLE: code_to_mode = ST_IDLE;
			MODE_HALT: code_to_mode = ST_HALT;
			default: code_to_mode = ST_ACTIVE;
		endcase
	endfunction : code_to_mode

	function automatic logic [1:0] mode_to_code(input mode_type m);
		case (m)
			ST_PSAVE: mode_to_code = MODE_PSAVE;
			ST_IDLE: mode_to_code = MODE_IDLE;
			ST_HALT: mode_to_code = MODE_HALT;
			default: mode_to_code = MODE_ACTIVE;
		endcase
	endfunction : mode_to_code

	// ============================================================
	// Registers
	logic [DATA_W-1:0] prescaler;
	power_ctrl_type ctrl;
	module_en_type men;
	mode_type mode;
	logic lf_s1, lf_s2, lf_s3, lf_level;
	logic wk_s1, wk_s2, wk_s3;
	logic [8:0] slow_cnt;
	logic [1:0] aux_tick;

	// Address decode
	wire wr_pre = bus.wr && bus.addr == AUX_PRESCALER_ADDR;
	wire wr_ctrl = bus.wr && bus.addr == POWER_CTRL_ADDR;
	wire wr_men = bus.wr && bus.addr == MODULE_EN_ADDR;

	// Mode flags
	wire is_active = mode == ST_ACTIVE;
	wire is_psave = mode == ST_PSAVE;
	wire is_halt = mode == ST_HALT;
	wire is_low = mode == ST_PSAVE || mode == ST_IDLE;

	// Wake request once the second and third stages are both high
	wire wake_seen = wk_s2 && wk_s3;
	wire wake_now = wake_seen && (mode == ST_IDLE || is_halt);

	// Low-frequency edge once the second and third stages agree
	wire lf_agree = lf_s2 == lf_s3;
	wire lf_rise = lf_agree && lf_s3 && !lf_level;

	// Next mode: a wake-up beats a simultaneous software write
	wire mode_type next_mode = wake_now ? ST_ACTIVE
		: wr_ctrl ? code_to_mode(bus.wdata[1:0]) : mode;

	// Oscillator disable is honoured only with a low-frequency slow source
	wire dmc_eff = ctrl.main_osc_disable_bit && !ctrl.slow_from_main;

	// Oscillator and PLL state per mode
	wire next_hf_osc_on = is_active ? 1'b1
		: is_halt ? 1'b0
		: !(dmc_eff || (ctrl.hcc_main && llc_sleep
		&& !ctrl.slow_from_main));
	wire next_pll_on = is_active ? 1'b1
		: is_halt ? 1'b0
		: !(ctrl.pll_disable_bit || (ctrl.hcc_pll && llc_sleep));

	// System clock source per mode
	wire [1:0] next_sys_clk_sel = is_active
		? (men.sys_from_pll ? SYS_PLL : SYS_MAIN)
		: is_psave ? SYS_SLOW : SYS_NONE;

	// Slow clock divider from the main clock, 2 x (divisor + 1)
	wire [8:0] slow_lim = {SLOW_DIV, 1'b1};
	wire slow_wrap = slow_cnt == slow_lim;
	wire [8:0] next_slow_cnt = (!main_clk_on || slow_wrap) ? 9'h000
		: 9'(slow_cnt + 9'h001);
	wire next_slow_tick = is_halt ? 1'b0
		: ctrl.slow_from_main ? (slow_wrap && main_clk_on)
		: lf_rise;

	// Processor stall: interrupt releases, else sleep holds
	wire next_cpu_stalled = irq ? 1'b0 : (sleep_req || cpu_stalled);

	// Readback mux, unmapped addresses read zero
	wire [DATA_W-1:0] status_word = {1'b0, cpu_stalled, lf_osc_on,
		main_clk_on, pll_on, hf_osc_on, mode_to_code(mode)};
	wire [DATA_W-1:0] ctrl_word = {1'b0, ctrl[6:2], mode_to_code(mode)};
	wire [DATA_W-1:0] rd_mux =
		bus.addr == AUX_PRESCALER_ADDR ? prescaler
		: bus.addr == POWER_CTRL_ADDR ? ctrl_word
		: bus.addr == MODULE_EN_ADDR ? men
		: bus.addr == STATUS_ADDR ? status_word : 8'h00;
	wire [DATA_W-1:0] next_rdata = bus.rd ? rd_mux : 8'h00;

	// ============================================================
	// Software registers
	always_ff @(posedge core_clk) begin
		if (srst) begin
			prescaler <= AUX_PRESCALER_RST;
			ctrl <= POWER_CTRL_RST;
			men <= MODULE_EN_RST;
		end else begin
			if (wr_pre) begin
				prescaler <= bus.wdata;
			end
			if (wr_ctrl) begin
				ctrl <= {1'b0, bus.wdata[6:0]};
			end
			if (wr_men) begin
				men <= bus.wdata;
			end
		end
	end

	// Mode state
	always_ff @(posedge core_clk) begin
		if (srst) begin
			mode <= ST_ACTIVE;
		end else begin
			mode <= next_mode;
		end
	end

	// Pin synchronisers
	always_ff @(posedge core_clk) begin
		if (srst) begin
			{lf_s1, lf_s2, lf_s3, lf_level} <= 4'h0;
			{wk_s1, wk_s2, wk_s3} <= 3'h0;
		end else begin
			{lf_s1, lf_s2, lf_s3} <= {lf_clk_pin, lf_s1, lf_s2};
			{wk_s1, wk_s2, wk_s3} <= {wake_pin, wk_s1, wk_s2};
			if (lf_agree) begin
				lf_level <= lf_s3;
			end
		end
	end

	// Clock state outputs
	always_ff @(posedge core_clk) begin
		if (srst) begin
			hf_osc_on <= 1'b1;
			pll_on <= 1'b1;
			main_clk_on <= 1'b1;
			sys_clk_sel <= SYS_MAIN;
			slow_tick <= 1'b0;
			slow_cnt <= 9'h000;
		end else begin
			hf_osc_on <= next_hf_osc_on;
			pll_on <= next_pll_on;
			main_clk_on <= next_hf_osc_on;
			sys_clk_sel <= next_sys_clk_sel;
			slow_tick <= next_slow_tick;
			slow_cnt <= next_slow_cnt;
		end
	end

	// Module gates and processor stall
	always_ff @(posedge core_clk) begin
		if (srst) begin
			lf_osc_on <= 1'b1;
			watchdog_clk_on <= 1'b1;
			conv_clk_on <= 1'b0;
			conv_en <= 1'b0;
			rng_osc_on <= 1'b0;
			radio_clk_slow <= 1'b0;
			radio_aux_ok <= 1'b0;
			spare_on <= 2'h0;
			cpu_stalled <= 1'b0;
			rdata <= 8'h00;
		end else begin
			lf_osc_on <= 1'b1;
			watchdog_clk_on <= !is_halt;
			conv_en <= men.converter_en;
			conv_clk_on <= men.converter_en && !is_halt;
			rng_osc_on <= men.rng_en;
			radio_clk_slow <= men.radio_use_slow;
			radio_aux_ok <= main_clk_on && men.aux1_en;
			spare_on <= is_halt || (mode == ST_IDLE) ? 2'h0
				: men.spare_en;
			cpu_stalled <= next_cpu_stalled;
			rdata <= next_rdata;
		end
	end

	// ============================================================
	// Auxiliary clock dividers
	for (genvar i = 0; i < 2; i++) begin : g_aux
		logic [AUX_DIV_W-1:0] cnt;
		wire [AUX_DIV_W-1:0] div =
			prescaler[AUX1_DIV_LSB + i*AUX_DIV_W +: AUX_DIV_W];
		wire run = main_clk_on && men[i];
		wire wrap = cnt == div;
		// Pulse once every divisor plus one main clock cycles
		always_ff @(posedge core_clk) begin
			if (srst || !run) begin
				cnt <= '0;
				aux_tick[i] <= 1'b0;
			end else begin
				cnt <= wrap ? '0 : AUX_DIV_W'(cnt + 1'b1);
				aux_tick[i] <= wrap;
			end
		end
	end

	assign aux1_tick = aux_tick[0];
	assign aux2_tick = aux_tick[1];

	// ============================================================
	// Assertions
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (srst);

	reset_values_a: assert property ($fell(srst) |->
		prescaler == 8'hff && mode == ST_ACTIVE && ctrl == 8'h00)
		else $error("reset state wrong");
	aux1_period_a: assert property ((aux1_tick && prescaler[3:0] == 4'h1
		&& $stable(prescaler) && men.aux1_en && main_clk_on) |=>
		!aux1_tick)
		else $error("aux1 period too short");
	aux2_period_a: assert property ((aux2_tick && prescaler[7:4] == 4'h2
		&& $stable(prescaler) && men.aux2_en && main_clk_on) |=>
		!aux2_tick ##1 !aux2_tick)
		else $error("aux2 period too short");
	aux_gate_a: assert property (!main_clk_on |=> !aux1_tick && !aux2_tick)
		else $error("aux clock without main clock");
	active_clocks_a: assert property (is_active |=>
		hf_osc_on && sys_clk_sel != SYS_NONE)
		else $error("active mode lost main clock");
	psave_sys_a: assert property (is_psave |=> sys_clk_sel == SYS_SLOW)
		else $error("power save not on slow clock");
	halt_stop_a: assert property (is_halt |=>
		!hf_osc_on && !pll_on && !slow_tick && !main_clk_on)
		else $error("halt left a clock running");
	osc_keep_a: assert property ((is_low && ctrl.slow_from_main) |=>
		hf_osc_on)
		else $error("oscillator off with main slow source");
	wake_exit_a: assert property ((is_halt && wake_seen) |=>
		mode == ST_ACTIVE)
		else $error("wake-up did not leave halt");
	sleep_stall_a: assert property ((sleep_req && !irq) |=>
		cpu_stalled)
		else $error("sleep did not stall");
	irq_release_a: assert property (irq |=> !cpu_stalled)
		else $error("interrupt did not release");
	lf_always_a: assert property (lf_osc_on)
		else $error("low-frequency oscillator stopped");

	// Main scenarios
	halt_cover_c: cover property (is_halt ##1 wake_now ##1 is_active);
	psave_cover_c: cover property (is_psave ##1 !hf_osc_on);
	aux_cover_c: cover property (aux1_tick ##[1:16] aux1_tick);

endmodule : power_mode_manager
`default_nettype wire

//--- tb/power_mode_manager_tb.sv
`timescale 1ns/1ns
`default_nettype none
module power_mode_manager_tb;
	import power_mode_pkg::*;
	logic core_clk;
	logic srst;
	reg_req_type bus;
	logic [7:0] rdata;
	logic lf_clk_pin, wake_pin, sleep_req, irq, llc_sleep;
	logic hf_osc_on, pll_on, lf_osc_on, main_clk_on, slow_tick;
	logic watchdog_clk_on, aux1_tick, aux2_tick, conv_clk_on, conv_en;
	logic rng_osc_on, radio_clk_slow, radio_aux_ok, cpu_stalled;
	logic [1:0] sys_clk_sel, spare_on;
	logic [3:0] lf_cnt;
	int miscompares, samples_checked;
	int p, a1, a2, sl, i;
	logic [7:0] mctl [8] = '{8'h00, 8'h01, 8'h02, 8'h05, 8'h45, 8'h04,
		8'h11, 8'h03};
	logic [1:0] msel [8] = '{2'h1, 2'h3, 2'h0, 2'h3, 2'h3, 2'h1, 2'h3, 2'h0};
	logic [3:0] mon [8] = '{4'hf, 4'hf, 4'hf, 4'h9, 4'hf, 4'hf, 4'h9, 4'h8};

	// ============================================================
	// Design under test, short slow divider
	power_mode_manager #(.SLOW_DIV(8'h02)) uut (
		.core_clk(core_clk), .srst(srst), .bus(bus), .rdata(rdata),
		.lf_clk_pin(lf_clk_pin), .wake_pin(wake_pin),
		.sleep_req(sleep_req), .irq(irq), .llc_sleep(llc_sleep),
		.hf_osc_on(hf_osc_on), .pll_on(pll_on), .lf_osc_on(lf_osc_on),
		.main_clk_on(main_clk_on), .sys_clk_sel(sys_clk_sel),
		.slow_tick(slow_tick), .watchdog_clk_on(watchdog_clk_on),
		.aux1_tick(aux1_tick), .aux2_tick(aux2_tick),
		.conv_clk_on(conv_clk_on), .conv_en(conv_en),
		.rng_osc_on(rng_osc_on), .radio_clk_slow(radio_clk_slow),
		.radio_aux_ok(radio_aux_ok), .spare_on(spare_on),
		.cpu_stalled(cpu_stalled));

	// Core clock, 8 ns period
	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end

	// Low-frequency clock, sped up to 32 core cycles
	always @(posedge core_clk) begin
		lf_cnt <= lf_cnt + 4'h1;
		if (lf_cnt == 4'hf) lf_clk_pin <= ~lf_clk_pin;
	end

	// ============================================================
	// Tasks
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic cycles(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask : cycles

	task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
		@(posedge core_clk);
		bus.wr <= 1'b1;
		bus.addr <= a;
		bus.wdata <= d;
		@(posedge core_clk);
		bus.wr <= 1'b0;
	endtask : wr_reg

	task automatic rd_reg(input logic [3:0] a, input logic [7:0] exp);
		@(posedge core_clk);
		bus.rd <= 1'b1;
		bus.addr <= a;
		@(posedge core_clk);
		bus.rd <= 1'b0;
		#1;
		chk(rdata, exp);
	endtask : rd_reg

	// Cycles between two ticks of one auxiliary clock
	task automatic period(input bit two, output int n);
		n = 0;
		do cycles(1); while ((two ? aux2_tick : aux1_tick) !== 1'b1 && ++n < 40);
		n = 0;
		do begin
			cycles(1);
			n++;
		end while ((two ? aux2_tick : aux1_tick) !== 1'b1 && n < 40);
	endtask : period

	// Tick counts over a window
	task automatic ticks(input int n);
		a1 = 0;
		a2 = 0;
		sl = 0;
		repeat (n) begin
			cycles(1);
			a1 += int'(aux1_tick === 1'b1);
			a2 += int'(aux2_tick === 1'b1);
			sl += int'(slow_tick === 1'b1);
		end
	endtask : ticks

	task automatic tally_and_finish;
		$display("compares=%0d mismatches=%0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : tally_and_finish

	// ============================================================
	// Hang guard
	initial begin
		#400000;
		miscompares++;
		tally_and_finish;
	end

	// Main sequence
	initial begin
		srst = 1'b1;
		bus = '0;
		{lf_clk_pin, wake_pin, sleep_req, irq} = 4'h0;
		llc_sleep = 1'b1;
		lf_cnt = 4'h0;
		miscompares = 0;
		samples_checked = 0;
		repeat (12) @(posedge core_clk);
		srst <= 1'b0;
		rd_reg(AUX_PRESCALER_ADDR, 8'hff);
		rd_reg(POWER_CTRL_ADDR, 8'h00);
		rd_reg(STATUS_ADDR, 8'h3c);
		chk({6'h0, sys_clk_sel}, 8'h01);
		rd_reg(4'hf, 8'h00);
		$display("reset test done");
		wr_reg(AUX_PRESCALER_ADDR, 8'h21);
		wr_reg(4'h9, 8'h55);
		rd_reg(AUX_PRESCALER_ADDR, 8'h21);
		period(1'b0, p);
		chk(8'(p), 8'h02);
		period(1'b1, p);
		chk(8'(p), 8'h03);
		wr_reg(POWER_CTRL_ADDR, 8'h80);
		rd_reg(POWER_CTRL_ADDR, 8'h00);
		$display("prescaler test done");
		wr_reg(MODULE_EN_ADDR, 8'hdf);
		cycles(3);
		chk({2'h0, spare_on, conv_en, rng_osc_on, radio_clk_slow,
			radio_aux_ok}, 8'h3f);
		ticks(100);
		chk(8'(sl > 0), 8'h01);
		for (i = 0; i < 8; i++) begin
			wr_reg(POWER_CTRL_ADDR, mctl[i]);
			cycles(4);
			chk({6'h0, sys_clk_sel}, {6'h0, msel[i]});
			chk({4'h0, lf_osc_on, hf_osc_on, main_clk_on, watchdog_clk_on},
				{4'h0, mon[i]});
			if (i == 2) chk({6'h0, spare_on}, 8'h00);
		end
		ticks(80);
		chk({5'h0, a1 != 0, a2 != 0, sl != 0}, 8'h00);
		chk({5'h0, conv_en, conv_clk_on, rng_osc_on}, 8'h05);
		$display("mode test done");
		@(posedge core_clk);
		wake_pin <= 1'b1;
		cycles(8);
		@(posedge core_clk);
		wake_pin <= 1'b0;
		rd_reg(STATUS_ADDR, 8'h3c);
		chk({6'h0, sys_clk_sel}, 8'h01);
		$display("wake test done");
		@(posedge core_clk);
		sleep_req <= 1'b1;
		@(posedge core_clk);
		sleep_req <= 1'b0;
		cycles(2);
		chk({7'h0, cpu_stalled}, 8'h01);
		rd_reg(STATUS_ADDR, 8'h7c);
		@(posedge core_clk);
		irq <= 1'b1;
		@(posedge core_clk);
		irq <= 1'b0;
		cycles(2);
		chk({7'h0, cpu_stalled}, 8'h00);
		$display("sleep test done");
		wr_reg(POWER_CTRL_ADDR, 8'h01);
		cycles(4);
		@(posedge core_clk);
		srst <= 1'b1;
		repeat (12) @(posedge core_clk);
		srst <= 1'b0;
		rd_reg(POWER_CTRL_ADDR, 8'h00);
		rd_reg(AUX_PRESCALER_ADDR, 8'hff);
		chk({6'h0, sys_clk_sel}, 8'h01);
		$display("second reset test done");
		tally_and_finish;
	end
endmodule : power_mode_manager_tb
`default_nettype wire
